// >>> logic/dttd_pkg.sv
package dttd_pkg;
  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_CTL8 = 4'h0;
  localparam logic [3:0] IDX_SHR = 4'h1;
  localparam logic [3:0] IDX_CTL16 = 4'h2;
  localparam logic [3:0] IDX_ENS = 4'h3;
  localparam logic [3:0] IDX_RLD8H = 4'h4;
  localparam logic [3:0] IDX_RLD8L = 4'h5;
  localparam logic [3:0] IDX_RLD16L = 4'h6;
  localparam logic [3:0] IDX_RLD16H = 4'h7;
  localparam logic [3:0] IDX_CAP16L = 4'h8;
  localparam logic [3:0] IDX_CAP16H = 4'h9;
  localparam logic [3:0] IDX_CAP8L = 4'ha;
  localparam logic [3:0] IDX_CAP8H = 4'hb;
  localparam int ADDR_W = 6;
  // timer8_control bits
  localparam int B8_PIN = 0;
  localparam int B8_MASK = 1;
  localparam int B8_TOUT = 5;
  localparam int B8_SINGLE = 6;
  localparam int B8_EN = 7;
  // shared_timer_control bits
  localparam int BS_LVL16 = 0;
  localparam int BS_LVL8 = 1;
  localparam int BS_SUB_LO = 2;
  localparam int BS_SUB_HI = 3;
  localparam int BS_MODE = 6;
  localparam int BS_SEL = 7;
  // timer16_control bits
  localparam int B16_PIN = 0;
  localparam int B16_SINGLE = 6;
  // timer_enable_sync_control bits
  localparam int BE_EN16 = 0;
  localparam int BE_EN8 = 1;
  localparam int BE_SYNC = 2;
  localparam logic [4:0] ENS_RSVD = 5'h1f;
  // sub-mode codes, filter lengths, reset byte and short count end
  localparam logic [1:0] SUB_NORMAL = 2'h0;
  localparam logic [1:0] SUB_PINGPONG = 2'h1;
  localparam logic [1:0] SUB_FORCE0 = 2'h2;
  localparam logic [1:0] SUB_FORCE1 = 2'h3;
  localparam logic [3:0] FILT_NONE = 4'h1;
  localparam logic [3:0] FILT_SHORT = 4'h4;
  localparam logic [3:0] FILT_LONG = 4'h8;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] CNT8_END = 8'hff;
endpackage : dttd_pkg

// >>> logic/dttd_top.sv
// Functional notes
// [R1] short high-time capture gets the count taken while input was one
// [R2] short low-time capture gets the count taken while input was zero
// [R3] long capture split: upper byte at 0x09, lower byte at 0x08
// [R4] capture registers ignore writes; reads give latest capture
// [R5] mask bit 1 of timer8_control gates the time-out interrupt
// [R6] bit 0 of timer8_control puts short timer output on its pin
// [R7] writing one to the short timer enable starts it
// [R8] single/modulo selector: 0 reloads at terminal count, 1 stops
// [R9] time-out flag sets at terminal count, cleared only by writing one
// [R10] software clears the time-out flag before enabling the timers
// [R11] first short count may be partial; no alignment needed
// [R12] read-modify-write of flag bits may clear them; software beware
// [R13] transmit sub-mode: normal, ping-pong, long output forced 0 or 1
// [R14] demodulation filter: none, 4 cycles, 8 cycles, reserved
// [R15] transmit: bit 1 and bit 0 give short and long start levels
// [R16] demodulation: bit 1 flags a rising edge, write one clears
// [R17] demodulation: bit 0 flags a falling edge, write one clears
// [R18] mode field zero is transmit, anything else demodulation
// [R19] transmit: select bit routes combined output to its pin
// [R20] demodulation: select bit picks input pin; irq pin raises interrupt
// [R21] enable bits read running state; write 0 stops, 1 starts
// [R22] sync mode aligns first carrier pulse; reserved bits read ones
// [R23] demodulation: capture count at each qualified edge, then restart
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module dttd_top (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dttd_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irq_capable_input_pin,
  input wire logic alternate_input_pin,
  input wire logic port_short_dout,
  input wire logic port_long_dout,
  input wire logic port_comb_dout,
  output logic short_timer_pin,
  output logic long_timer_pin,
  output logic combined_output_pin,
  output logic timeout_irq,
  output logic external_interrupt_two
);
  import dttd_pkg::*;

  typedef struct packed {
    logic [7:0] ctl8;
    logic [7:0] shr;
    logic [7:0] ctl16;
    logic sync;
    logic en8;
    logic en16;
    logic rise;
    logic fall;
    logic tout;
    logic [7:0] rld8h;
    logic [7:0] rld8l;
    logic [15:0] rld16;
    logic [7:0] cap8h;
    logic [7:0] cap8l;
    logic [15:0] cap16;
    logic [7:0] cnt8;
    logic [15:0] cnt16;
    logic out8;
    logic out16;
    logic synced;
    logic filt;
    logic [3:0] fcnt;
    logic irq;
    logic ext;
    logic pin_s;
    logic pin_l;
    logic pin_c;
    logic rdy;
    logic err;
    logic [31:0] rdata;
  } dttd_state_t;

  dttd_state_t s_r;
  dttd_state_t s_nxt;

  function automatic logic hit(input logic [3:0] idx, input logic [3:0] want);
    hit = (idx == want);
  endfunction : hit

  function automatic logic [3:0] filt_len(input logic [1:0] code);
    case (code)
      2'h0: filt_len = FILT_NONE;
      2'h1: filt_len = FILT_SHORT;
      default: filt_len = FILT_LONG;
    endcase
  endfunction : filt_len

  //////////////////////////////////////////////////////////////////////
  logic [3:0] idx;
  logic mapped;
  logic wr;
  logic demod;
  logic [1:0] sub;
  logic raw;
  logic edge_r;
  logic edge_f;
  logic filt_take;
  logic tc8;
  logic tc16;
  logic out16_f;
  logic [7:0] rd8;

  assign idx = paddr[ADDR_W-1:2];
  assign mapped = (idx <= IDX_CAP8H);
  assign demod = s_r.shr[BS_MODE]; // [R18]
  assign sub = s_r.shr[BS_SUB_HI:BS_SUB_LO];
  // one means the interrupt-capable pin feeds the counters
  assign raw = s_r.shr[BS_SEL] ? irq_capable_input_pin : alternate_input_pin; // [R20]
  assign wr = psel && penable && s_r.rdy && pwrite && mapped;

  always_comb begin
    rd8 = RST_BYTE;
    case (idx)
      IDX_CTL8: begin
        rd8 = s_r.ctl8;
        rd8[B8_TOUT] = s_r.tout;
        rd8[B8_EN] = s_r.en8;
      end
      IDX_SHR: begin
        rd8 = s_r.shr;
        if (demod) begin
          rd8[BS_LVL8] = s_r.rise; // [R16]
          rd8[BS_LVL16] = s_r.fall; // [R17]
        end
      end
      IDX_CTL16: rd8 = s_r.ctl16;
      IDX_ENS: rd8 = {ENS_RSVD, s_r.sync, s_r.en8, s_r.en16}; // [R21] [R22]
      IDX_RLD8H: rd8 = s_r.rld8h;
      IDX_RLD8L: rd8 = s_r.rld8l;
      IDX_RLD16L: rd8 = s_r.rld16[7:0];
      IDX_RLD16H: rd8 = s_r.rld16[15:8];
      IDX_CAP16L: rd8 = s_r.cap16[7:0]; // [R3] [R4]
      IDX_CAP16H: rd8 = s_r.cap16[15:8]; // [R3] [R4]
      IDX_CAP8L: rd8 = s_r.cap8l; // [R4]
      IDX_CAP8H: rd8 = s_r.cap8h; // [R4]
      default: rd8 = RST_BYTE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  assign tc8 = !demod && s_r.en8 && (!s_r.sync || s_r.synced) && (s_r.cnt8 == RST_BYTE);
  assign tc16 = !demod && s_r.en16 && (s_r.cnt16 == {RST_BYTE, RST_BYTE});
  // filter decision sits outside the state process so edges never loop back into it
  assign filt_take = (raw != s_r.filt) && (s_r.fcnt + 4'h1 >= filt_len(sub)); // [R14]
  assign edge_r = demod && filt_take && raw;
  assign edge_f = demod && filt_take && !raw;
  // forced levels also reach the long pin in demodulation mode, where this field is the filter code
  assign out16_f = (sub == SUB_FORCE0) ? 1'b0 :
                   (sub == SUB_FORCE1) ? 1'b1 : s_r.out16; // [R13]

  always_comb begin
    logic start8;
    logic start16;
    logic clr;
    start8 = 1'b0;
    start16 = 1'b0;
    clr = 1'b0;
    s_nxt = s_r;
    s_nxt.rdy = 1'b0;
    s_nxt.ext = 1'b0;
    // apb: one wait state, answer registered
    if (psel && penable && !s_r.rdy) begin
      s_nxt.rdy = 1'b1;
      s_nxt.err = !mapped;
      s_nxt.rdata = {24'h000000, rd8};
    end
    if (wr) begin
      if (hit(idx, IDX_CTL8)) begin
        s_nxt.ctl8 = pwdata[7:0]; // [R5] [R6] [R8]
        if (pwdata[B8_TOUT]) begin
          clr = 1'b1; // [R9] [R12]
        end
        if (pwdata[B8_EN] && !s_r.en8) begin
          start8 = 1'b1; // [R7]
        end
      end
      if (hit(idx, IDX_SHR)) begin
        s_nxt.shr[7:2] = pwdata[7:2];
        if (demod) begin
          if (pwdata[BS_LVL8]) begin
            s_nxt.rise = 1'b0; // [R16]
          end
          if (pwdata[BS_LVL16]) begin
            s_nxt.fall = 1'b0; // [R17]
          end
        end else begin
          s_nxt.shr[1:0] = pwdata[1:0]; // [R15]
        end
      end
      if (hit(idx, IDX_CTL16)) begin
        s_nxt.ctl16 = pwdata[7:0];
      end
      if (hit(idx, IDX_ENS)) begin
        s_nxt.sync = pwdata[BE_SYNC];
        s_nxt.en8 = pwdata[BE_EN8]; // [R21]
        s_nxt.en16 = pwdata[BE_EN16]; // [R21]
        start8 = pwdata[BE_EN8] && !s_r.en8; // [R7]
        start16 = pwdata[BE_EN16] && !s_r.en16;
      end
      if (hit(idx, IDX_RLD8H)) begin
        s_nxt.rld8h = pwdata[7:0];
      end
      if (hit(idx, IDX_RLD8L)) begin
        s_nxt.rld8l = pwdata[7:0];
      end
      if (hit(idx, IDX_RLD16L)) begin
        s_nxt.rld16[7:0] = pwdata[7:0];
      end
      if (hit(idx, IDX_RLD16H)) begin
        s_nxt.rld16[15:8] = pwdata[7:0];
      end
    end
    if (clr) begin
      s_nxt.tout = 1'b0;
    end
    // input glitch filter; reserved code acts as the longest
    if (raw == s_r.filt) begin
      s_nxt.fcnt = 4'h0;
    end else if (filt_take) begin
      s_nxt.filt = raw; // [R14]
      s_nxt.fcnt = 4'h0;
    end else begin
      s_nxt.fcnt = s_r.fcnt + 4'h1;
    end
    if (!demod) begin
      // short timer: count down, toggle, reload for the new level
      if (tc8) begin
        s_nxt.out8 = !s_r.out8;
        s_nxt.cnt8 = s_r.out8 ? s_r.rld8l : s_r.rld8h;
        s_nxt.tout = 1'b1; // [R9]
        if (s_r.ctl8[B8_SINGLE] || sub == SUB_PINGPONG) begin
          s_nxt.en8 = 1'b0; // [R8]
        end
        if (sub == SUB_PINGPONG) begin
          s_nxt.en16 = 1'b1; // [R13]
          start16 = 1'b1;
        end
      end else if (s_r.en8 && (!s_r.sync || s_r.synced)) begin
        s_nxt.cnt8 = s_r.cnt8 - 8'h01; // [R11]
      end
      if (tc16) begin
        s_nxt.out16 = !s_r.out16;
        s_nxt.cnt16 = s_r.rld16;
        s_nxt.synced = 1'b1; // [R22]
        if (s_r.ctl16[B16_SINGLE] || sub == SUB_PINGPONG) begin
          s_nxt.en16 = 1'b0; // [R8]
        end
        if (sub == SUB_PINGPONG) begin
          s_nxt.en8 = 1'b1; // [R13]
          start8 = 1'b1;
        end
      end else if (s_r.en16) begin
        s_nxt.cnt16 = s_r.cnt16 - 16'h0001;
      end
    end else begin
      if (s_r.en8) begin
        s_nxt.cnt8 = s_r.cnt8 + 8'h01;
        if (s_r.cnt8 == CNT8_END) begin
          s_nxt.tout = 1'b1; // [R9]
        end
      end
      if (s_r.en16) begin
        s_nxt.cnt16 = s_r.cnt16 + 16'h0001;
      end
      if (edge_r || edge_f) begin
        if (edge_r) begin
          s_nxt.cap8l = s_r.cnt8; // [R2] [R23]
          s_nxt.rise = 1'b1; // [R16]
        end else begin
          s_nxt.cap8h = s_r.cnt8; // [R1] [R23]
          s_nxt.fall = 1'b1; // [R17]
        end
        s_nxt.cap16 = s_r.cnt16; // [R3] [R23]
        s_nxt.cnt8 = RST_BYTE;
        s_nxt.cnt16 = {RST_BYTE, RST_BYTE};
        s_nxt.ext = s_r.shr[BS_SEL]; // [R20]
      end
    end
    if (start8) begin
      s_nxt.out8 = s_r.shr[BS_LVL8]; // [R15]
      s_nxt.cnt8 = demod ? RST_BYTE : (s_r.shr[BS_LVL8] ? s_r.rld8h : s_r.rld8l);
      s_nxt.synced = 1'b0; // [R22]
      s_nxt.en8 = 1'b1; // [R7]
    end
    if (start16) begin
      s_nxt.out16 = s_r.shr[BS_LVL16]; // [R15]
      s_nxt.cnt16 = demod ? {RST_BYTE, RST_BYTE} : s_r.rld16;
    end
    // pins and interrupt are all registered
    s_nxt.pin_s = s_r.ctl8[B8_PIN] ? s_r.out8 : port_short_dout; // [R6]
    s_nxt.pin_l = s_r.ctl16[B16_PIN] ? out16_f : port_long_dout;
    s_nxt.pin_c = (!demod && s_r.shr[BS_SEL]) ? (s_r.out8 && out16_f) : port_comb_dout; // [R19]
    s_nxt.irq = s_r.tout && s_r.ctl8[B8_MASK]; // [R5]
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_r <= '0;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rdata;
  assign pready = s_r.rdy;
  assign pslverr = s_r.err;
  assign short_timer_pin = s_r.pin_s;
  assign long_timer_pin = s_r.pin_l;
  assign combined_output_pin = s_r.pin_c;
  assign timeout_irq = s_r.irq;
  assign external_interrupt_two = s_r.ext;

  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_cap_high_val: assert property (clk_en && edge_f |=> s_r.cap8h == $past(s_r.cnt8)) // [R1]
    else $error("high capture wrong");
  a_cap_low_val: assert property (clk_en && edge_r |=> s_r.cap8l == $past(s_r.cnt8)) // [R2]
    else $error("low capture wrong");
  a_cap16_split: assert property (clk_en && (edge_r || edge_f) |=> // [R3]
    s_r.cap16 == $past(s_r.cnt16) && s_r.cnt16 == 16'h0000)
    else $error("long capture wrong");
  a_cap_write_ign: assert property (clk_en && wr && idx >= IDX_CAP16L && !edge_r && !edge_f // [R4]
    |=> $stable(s_r.cap8h) && $stable(s_r.cap8l) && $stable(s_r.cap16))
    else $error("capture changed by write");
  a_irq_mask: assert property (clk_en |=> timeout_irq == ($past(s_r.tout) && // [R5]
    $past(s_r.ctl8[B8_MASK])))
    else $error("interrupt mask broken");
  a_tout_hold: assert property (clk_en && s_r.tout && !(wr && hit(idx, IDX_CTL8) && // [R9]
    pwdata[B8_TOUT]) |=> s_r.tout)
    else $error("timeout flag lost");
  a_tout_set: assert property (clk_en && tc8 |=> s_r.tout) // [R9]
    else $error("timeout flag not set");
  a_single_stop: assert property (clk_en && tc8 && s_r.ctl8[B8_SINGLE] && sub != SUB_PINGPONG // [R8]
    |=> !s_r.en8)
    else $error("single pass kept running");
  a_rise_flag: assert property (clk_en && edge_r |=> s_r.rise) // [R16]
    else $error("rising flag missed");
  a_ens_rsvd: assert property (clk_en && psel && penable && !pready && // [R22]
    hit(idx, IDX_ENS) |=> prdata[7:3] == ENS_RSVD)
    else $error("reserved bits not ones");
  a_apb_answer: assert property (psel && penable && !pready && clk_en |=> pready)
    else $error("apb answer late");
  a_fall_flag: assert property (clk_en && edge_f |=> s_r.fall) // [R17]
    else $error("falling flag missed");
  a_pin_port: assert property (clk_en && !s_r.ctl8[B8_PIN] |=> // [R6]
    short_timer_pin == $past(port_short_dout))
    else $error("short pin not port output");
  a_ext_quiet: assert property (clk_en && !s_r.shr[BS_SEL] |=> !external_interrupt_two) // [R20]
    else $error("interrupt from unselected pin");
  a_filter_glitch: assert property (clk_en && filt_len(sub) == FILT_LONG && // [R14]
    s_r.fcnt < 4'h7 |=> $stable(s_r.filt))
    else $error("glitch passed the filter");
  a_pingpong_hand: assert property (clk_en && tc8 && !tc16 && !wr && // [R13]
    sub == SUB_PINGPONG |=> s_r.en16 && !s_r.en8)
    else $error("ping-pong handover wrong");
  a_force_high: assert property (clk_en && s_r.ctl16[B16_PIN] && sub == SUB_FORCE1 // [R13]
    |=> long_timer_pin)
    else $error("long output not forced high");

  c_tx_toggle: cover property (tc8 && s_r.ctl8[B8_PIN]);
  c_demod_cap: cover property (edge_f ##[1:50] edge_r);
  c_pingpong: cover property (tc16 && sub == SUB_PINGPONG);
  c_sync_start: cover property (s_r.sync && s_r.en8 && !s_r.synced ##1 s_r.synced);
  c_filter_long: cover property (demod && filt_take && filt_len(sub) == FILT_LONG);
endmodule : dttd_top

// >>> testbench/dttd_pin_model.sv
`timescale 1ns/1ps
// far-side pin source: square wave on the irq-capable pin while burst is high
module dttd_pin_model (
  input wire logic ref_clk,
  input wire logic burst,
  input wire logic [7:0] hi_len,
  input wire logic [7:0] lo_len,
  output logic irq_capable_input_pin,
  output logic alternate_input_pin
);
  logic [7:0] cnt_r = 8'h00;
  logic irq_r = 1'b0;
  logic alt_r = 1'b0;
  assign irq_capable_input_pin = irq_r;
  assign alternate_input_pin = alt_r;
  // unselected pin toggles every cycle so a wrong input choice is seen
  always @(posedge ref_clk) begin
    alt_r <= ~alt_r;
    if (!burst) begin
      cnt_r <= 8'h00;
      irq_r <= 1'b0;
    end else if (cnt_r == (irq_r ? hi_len : lo_len) - 8'h01) begin
      irq_r <= ~irq_r;
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule : dttd_pin_model

// >>> testbench/dttd_top_tb_top.sv
`timescale 1ns/1ps
module dttd_top_tb_top;
  import dttd_pkg::*;
  logic ref_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [5:0] paddr = 6'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq_pin, alt_pin, burst = 1'b0;
  logic ps_d = 1'b0, pl_d = 1'b0, pc_d = 1'b0;
  logic s_pin, l_pin, c_pin, t_irq, x_irq;
  int fail_count = 0, total_checks = 0, x_seen = 0;
  logic [31:0] rd;
  logic err;
  dttd_top dut_u (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_capable_input_pin(irq_pin),
    .alternate_input_pin(alt_pin), .port_short_dout(ps_d), .port_long_dout(pl_d),
    .port_comb_dout(pc_d), .short_timer_pin(s_pin), .long_timer_pin(l_pin),
    .combined_output_pin(c_pin), .timeout_irq(t_irq), .external_interrupt_two(x_irq));
  dttd_pin_model pm_u (.ref_clk(ref_clk), .burst(burst), .hi_len(8'h0c), .lo_len(8'h09),
    .irq_capable_input_pin(irq_pin), .alternate_input_pin(alt_pin));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (x_irq === 1'b1) x_seen++;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chkr(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    total_checks++;
    if (!(got >= lo && got <= hi) || $isunknown(got)) begin
      fail_count++;
      $display("[ERR] %0t got %h outside %h..%h", $time, got, lo, hi);
    end
  endtask : chkr
  // apb: setup, access held until pready is sampled high
  task automatic apb(input logic w, input logic [3:0] idx, input logic [7:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [3:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk8(rd[7:0], exp);
  endtask : rdchk
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_cyc
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_map();
    rdchk(IDX_CTL8, 8'h00);
    rdchk(IDX_ENS, 8'hf8);
    apb(1'b1, IDX_ENS, 8'h04);
    rdchk(IDX_ENS, 8'hfc);
    apb(1'b1, IDX_ENS, 8'h00);
    apb(1'b0, 4'hc, 8'h00);
    chk8({7'h0, err}, 8'h01);
  endtask : t_reset_map
  // short timer: start level, tc flag, mask, reload or stop
  task automatic t_short(input logic [7:0] ctl, input logic lvl);
    apb(1'b1, IDX_CTL8, 8'h20);
    apb(1'b1, IDX_SHR, {6'h0, lvl, 1'b0});
    apb(1'b1, IDX_RLD8H, 8'h05);
    apb(1'b1, IDX_RLD8L, 8'h05);
    apb(1'b1, IDX_CTL8, ctl);
    wait_cyc(2);
    chk8({7'h0, s_pin}, {7'h0, lvl});
    rdchk(IDX_ENS, 8'hfa);
    wait_cyc(30);
    chk8({7'h0, t_irq}, {7'h0, ctl[B8_MASK]});
    rdchk(IDX_ENS, ctl[B8_SINGLE] ? 8'hf8 : 8'hfa);
    apb(1'b1, IDX_ENS, 8'h00);
    rdchk(IDX_ENS, 8'hf8);
    apb(1'b1, IDX_CTL8, 8'h00);
    rdchk(IDX_CTL8, 8'h20);
    apb(1'b1, IDX_CTL8, 8'h20);
    rdchk(IDX_CTL8, 8'h00);
    ps_d <= ~lvl;
    wait_cyc(3);
    chk8({7'h0, s_pin}, {7'h0, ~lvl});
  endtask : t_short
  // demodulation of a 12-high / 9-low wave on the irq-capable pin
  // low phase must outlast the 8-cycle filter; burst ends inside a low phase
  task automatic t_demod(input logic [1:0] filt);
    apb(1'b1, IDX_SHR, {2'b11, 2'b00, filt, 2'b11});
    apb(1'b1, IDX_ENS, 8'h03);
    x_seen = 0;
    burst <= 1'b1;
    wait_cyc(88);
    @(posedge ref_clk);
    burst <= 1'b0;
    wait_cyc(20);
    rdchk(IDX_SHR, {2'b11, 2'b00, filt, 2'b11});
    apb(1'b0, IDX_CAP8H, 8'h00);
    chkr(rd[7:0], 8'h0b, 8'h0d);
    apb(1'b0, IDX_CAP8L, 8'h00);
    chkr(rd[7:0], 8'h08, 8'h0a);
    rdchk(IDX_CAP16H, 8'h00);
    apb(1'b0, IDX_CAP16L, 8'h00);
    chkr(rd[7:0], 8'h08, 8'h0d);
    apb(1'b1, IDX_CAP8H, 8'h55);
    apb(1'b0, IDX_CAP8H, 8'h00);
    chkr(rd[7:0], 8'h0b, 8'h0d);
    chk8({7'h0, x_seen > 0}, 8'h01);
    apb(1'b1, IDX_SHR, {2'b11, 2'b00, filt, 2'b10});
    rdchk(IDX_SHR, {2'b11, 2'b00, filt, 2'b01});
    apb(1'b1, IDX_SHR, {2'b11, 2'b00, filt, 2'b01});
  endtask : t_demod
  // forced long output and combined pin in transmit mode
  task automatic t_outputs();
    // ping-pong: short terminal count hands over to the long timer
    apb(1'b1, IDX_ENS, 8'h00);
    apb(1'b1, IDX_RLD16L, 8'h40);
    apb(1'b1, IDX_SHR, 8'h04);
    apb(1'b1, IDX_ENS, 8'h02);
    wait_cyc(20);
    rdchk(IDX_ENS, 8'hf9);
    apb(1'b1, IDX_ENS, 8'h00);
    apb(1'b1, IDX_CTL16, 8'h01);
    for (int s = 2; s < 4; s++) begin
      apb(1'b1, IDX_SHR, {6'h0, s[1:0]} << 2);
      wait_cyc(3);
      chk8({7'h0, l_pin}, {7'h0, s[0]});
    end
    @(posedge ref_clk);
    pc_d <= 1'b1;
    apb(1'b1, IDX_SHR, 8'h88);
    wait_cyc(3);
    chk8({7'h0, c_pin}, 8'h00);
    apb(1'b1, IDX_SHR, 8'h08);
    wait_cyc(3);
    chk8({7'h0, c_pin}, 8'h01);
  endtask : t_outputs
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    fail_count++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset_map();
    t_short(8'h83, 1'b1);
    t_short(8'hc1, 1'b0);
    t_short(8'h81, 1'b0);
    for (int f = 0; f < 3; f++) t_demod(f[1:0]);
    t_outputs();
    close_out();
  end
endmodule : dttd_top_tb_top
